/* File: common/eis_pkg.sv */
// Package of register offsets, field layouts and reset values for the external interrupt front end.
package eis_pkg;
    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0] OFS_ONE_CONTROL  = 8'h00;
    localparam logic [7:0] OFS_TWO_CONTROL  = 8'h04;
    localparam logic [7:0] OFS_NMI_CONTROL  = 8'h08;
    localparam logic [7:0] OFS_ONE_PIN_SEL  = 8'h0C;
    localparam logic [7:0] OFS_TWO_PIN_SEL  = 8'h10;
    localparam logic [7:0] OFS_NMI_PIN_SEL  = 8'h14;
    localparam logic [7:0] OFS_STAMP        = 8'h18;
    localparam logic [7:0] OFS_PIN_STATUS   = 8'h1C;
    // Control register fields.
    localparam int CTL_ENABLE_BIT   = 0;
    localparam int CTL_SELECT_BIT   = 1;
    localparam int CTL_POL_LSB      = 2;
    localparam int CTL_WIDTH        = 4;
    localparam int SEL_WIDTH        = 5;
    // Polarity codes.
    localparam logic [1:0] POL_RISING   = 2'h0;
    localparam logic [1:0] POL_FALLING  = 2'h1;
    localparam logic [1:0] POL_BOTH     = 2'h2;
    // Reset values.
    localparam logic [3:0] CTL_RESET    = 4'h0;
    localparam logic [4:0] SEL_RESET    = 5'h00;
    localparam logic [31:0] STAMP_RESET = 32'h0000_0000;
endpackage

/* File: design/eis_edge_detect.sv */
// One edge detector that picks a pin, compares samples and raises one-cycle pulses.
`timescale 1ns/1ps
module eis_edge_detect (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [31:0] pins_sync,
    input  wire logic [4:0]  pin_select,
    input  wire logic [1:0]  polarity,
    output logic             level,
    output logic             edge_pulse
);
    logic prev_q;
    logic cur;
    logic rise;
    logic fall;
    logic hit;

    assign cur  = pins_sync[pin_select];
    assign rise = cur & ~prev_q;
    assign fall = ~cur & prev_q;
    assign hit  = (polarity == eis_pkg::POL_RISING)  ? rise :
                  (polarity == eis_pkg::POL_FALLING) ? fall :
                  (polarity == eis_pkg::POL_BOTH)    ? (rise | fall) : 1'b0;
    assign level = cur;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q     <= 1'b0;
            edge_pulse <= 1'b0;
        end else begin
            prev_q     <= cur;
            edge_pulse <= hit;
        end
    end

    edge_one_cycle_a: assert property (@(posedge hclk) disable iff (!hresetn)
        edge_pulse |=> !edge_pulse || (polarity == eis_pkg::POL_BOTH))
        else $error("edge pulse held for two cycles");
    rise_seen_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (polarity == eis_pkg::POL_RISING && rise) |=> edge_pulse)
        else $error("rising edge not reported");
    fall_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (polarity == eis_pkg::POL_FALLING && rise) |=> !edge_pulse)
        else $error("rising edge reported in falling mode");
endmodule

/* File: design/eis_ext_irq.sv */
// Top of the external interrupt front end with its AHB-Lite register slave.
//
// How it works
// - Rising, falling or both edges selectable.
// - Separate polarity control per external interrupt.
// - Enable and select both one: no nonmaskable.
// - Then level thirteen pulses on the selected edges of selected pin.
// - Then the time stamp counter runs.
// - Each source picks any pin 0 to 31.
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module eis_ext_irq (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [31:0] gpio_pins,
    output logic             ext_irq_one,
    output logic             ext_irq_two,
    output logic             ext_nonmaskable_irq,
    output logic             core_level_thirteen_irq
);
    logic [31:0] pins_meta_q;
    logic [31:0] pins_sync_q;
    logic [3:0]  ctl_q [3];
    logic [4:0]  sel_q [3];
    logic [31:0] stamp_q;
    logic [2:0]  pulse;
    logic [2:0]  level;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic        rd_take;
    logic        wr_take;
    logic [31:0] rd_word;
    logic        nmi_redirect;
    logic        irq_one_q;
    logic        irq_two_q;
    logic        irq_nmi_q;
    logic        irq_13_q;

    // Pins are asynchronous, so they pass two flops before use.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_meta_q <= 32'h0000_0000;
            pins_sync_q <= 32'h0000_0000;
        end else begin
            pins_meta_q <= gpio_pins;
            pins_sync_q <= pins_meta_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_src
            eis_edge_detect eis_edge_detect_i (
                .hclk       (hclk),
                .hresetn    (hresetn),
                .pins_sync  (pins_sync_q),
                .pin_select (sel_q[g]),
                .polarity   (ctl_q[g][eis_pkg::CTL_POL_LSB +: 2]),
                .level      (level[g]),
                .edge_pulse (pulse[g])
            );
        end
    endgenerate

    assign nmi_redirect = ctl_q[2][eis_pkg::CTL_ENABLE_BIT]
                        & ctl_q[2][eis_pkg::CTL_SELECT_BIT];

    // Bus: reads answer in the data phase with no wait; writes land at data phase.
    assign rd_take = hsel & hready & htrans[1] & ~hwrite;
    assign wr_take = hsel & hready & htrans[1] & hwrite;

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (haddr[7:0])
            eis_pkg::OFS_ONE_CONTROL: rd_word = {28'h0000000, ctl_q[0]};
            eis_pkg::OFS_TWO_CONTROL: rd_word = {28'h0000000, ctl_q[1]};
            eis_pkg::OFS_NMI_CONTROL: rd_word = {28'h0000000, ctl_q[2]};
            eis_pkg::OFS_ONE_PIN_SEL: rd_word = {27'h0000000, sel_q[0]};
            eis_pkg::OFS_TWO_PIN_SEL: rd_word = {27'h0000000, sel_q[1]};
            eis_pkg::OFS_NMI_PIN_SEL: rd_word = {27'h0000000, sel_q[2]};
            eis_pkg::OFS_STAMP:       rd_word = stamp_q;
            eis_pkg::OFS_PIN_STATUS:  rd_word = {29'h0000000, level};
            default:                  rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= wr_take;
            wr_addr_q <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rd_take) begin
                hrdata <= rd_word;
            end
        end
    end

    generate
        for (g = 0; g < 3; g++) begin : g_reg
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    ctl_q[g] <= eis_pkg::CTL_RESET;
                    sel_q[g] <= eis_pkg::SEL_RESET;
                end else if (wr_pend_q) begin
                    if (wr_addr_q == eis_pkg::OFS_ONE_CONTROL + 8'(4 * g)) begin
                        ctl_q[g] <= hwdata[3:0];
                    end
                    if (wr_addr_q == eis_pkg::OFS_ONE_PIN_SEL + 8'(4 * g)) begin
                        sel_q[g] <= hwdata[4:0];
                    end
                end
            end
        end
    endgenerate

    // Stamp counter runs only in redirect mode; a write of the offset reloads it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stamp_q <= eis_pkg::STAMP_RESET;
        end else if (wr_pend_q && wr_addr_q == eis_pkg::OFS_STAMP) begin
            stamp_q <= hwdata;
        end else if (nmi_redirect) begin
            stamp_q <= stamp_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_one_q <= 1'b0;
            irq_two_q <= 1'b0;
            irq_nmi_q <= 1'b0;
            irq_13_q  <= 1'b0;
        end else begin
            irq_one_q <= pulse[0] & ctl_q[0][eis_pkg::CTL_ENABLE_BIT];
            irq_two_q <= pulse[1] & ctl_q[1][eis_pkg::CTL_ENABLE_BIT];
            irq_nmi_q <= pulse[2] & ctl_q[2][eis_pkg::CTL_ENABLE_BIT]
                         & ~nmi_redirect;
            irq_13_q  <= pulse[2] & nmi_redirect;
        end
    end

    assign ext_irq_one             = irq_one_q;
    assign ext_irq_two             = irq_two_q;
    assign ext_nonmaskable_irq     = irq_nmi_q;
    assign core_level_thirteen_irq = irq_13_q;

    no_nmi_redirect_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(nmi_redirect) |-> !ext_nonmaskable_irq)
        else $error("nonmaskable fired in redirect mode");
    level13_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pulse[2] && nmi_redirect) |=> core_level_thirteen_irq)
        else $error("level thirteen missed a redirected edge");
    level13_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !nmi_redirect |=> !core_level_thirteen_irq)
        else $error("level thirteen fired outside redirect");
    stamp_runs_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (nmi_redirect && !wr_pend_q) |=> stamp_q == $past(stamp_q) + 32'h1)
        else $error("stamp counter did not advance");
    stamp_holds_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!nmi_redirect && !wr_pend_q) |=> $stable(stamp_q))
        else $error("stamp counter moved while disabled");
    one_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pulse[0] && ctl_q[0][eis_pkg::CTL_ENABLE_BIT]) |=> ext_irq_one)
        else $error("first interrupt missed its edge");
endmodule

/* File: verif/eis_core_model.sv */
// Model of the core's interrupt inputs that counts every one-cycle request.
`timescale 1ns/1ps
module eis_core_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [3:0] irq,
    output logic [3:0][7:0] cnt
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                cnt[i] <= cnt[i] + 8'(irq[i]);
            end
        end
    end
endmodule

/* File: verif/external_interrupt_select_edge_tb.sv */
// Self-checking bench for the external interrupt front end.
`timescale 1ns/1ps
module external_interrupt_select_edge_tb;
    logic            hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0]      htrans;
    logic [2:0]      hsize;
    logic [4:0]      sel;
    logic [4:0]      sel_of [3];
    logic [3:0]      irq;
    logic [31:0]     haddr, hwdata, hrdata, gpio_pins, rd, a;
    logic [3:0][7:0] cnt, d;
    int              fails, comparisons;
    always #25 hclk = ~hclk;
    eis_ext_irq eis_ext_irq_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .gpio_pins(gpio_pins),
        .ext_irq_one(irq[0]), .ext_irq_two(irq[1]),
        .ext_nonmaskable_irq(irq[2]), .core_level_thirteen_irq(irq[3]));
    eis_core_model eis_core_model_i (.hclk(hclk), .hresetn(hresetn),
        .irq(irq), .cnt(cnt));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ad};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check(32'(hresp), 32'h0);
    endtask
    // Gives the pin a clean low, then one rise and one fall, and returns the pulse counts.
    task automatic pulse(input logic [4:0] p);
        logic [3:0][7:0] c0;
        @(posedge hclk);
        gpio_pins[p] <= 1'b0;
        repeat (8) @(posedge hclk);
        c0 = cnt;
        gpio_pins[p] <= 1'b1;
        repeat (8) @(posedge hclk);
        gpio_pins[p] <= 1'b0;
        repeat (8) @(posedge hclk);
        for (int i = 0; i < 4; i++) d[i] = cnt[i] - c0[i];
    endtask
    // Modes 0 to 2 are the polarity codes, 3 the unused code and 4 a disabled input.
    function automatic logic [7:0] expect_n(input int m);
        return (m == 2) ? 8'h02 : ((m >= 3) ? 8'h00 : 8'h01);
    endfunction
    task automatic close_out();
        $display("counts: comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        close_out();
    end
    initial begin
        {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        void'($urandom(55));
        gpio_pins = $urandom;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        for (int o = 0; o < 28; o += 4) begin
            bus(1'b0, 8'(o), 32'h0);
            check(rd, 32'h0);
        end
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        bus(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0);
        $display("test reset and unmapped done");
        for (int c = 0; c < 3; c++) begin
            for (int m = 0; m < 5; m++) begin
                sel = 5'($urandom);
                bus(1'b1, 8'(12 + 4 * c), {27'h0, sel});
                bus(1'b0, 8'(12 + 4 * c), 32'h0);
                check(rd, {27'h0, sel});
                sel_of[c] = sel;
                bus(1'b1, 8'(4 * c), (m == 4) ? 32'h0 : 32'(m * 4 + 1));
                pulse(sel);
                check(32'(d[c]), 32'(expect_n(m)));
            end
            $display("test channel %0d done", c);
        end
        sel = 5'($urandom);
        bus(1'b1, eis_pkg::OFS_NMI_PIN_SEL, {27'h0, sel});
        sel_of[2] = sel;
        bus(1'b1, eis_pkg::OFS_NMI_CONTROL, 32'h0000_000B);
        pulse(sel);
        check(32'(d[2]), 32'h0);
        check(32'(d[3]), 32'h2);
        bus(1'b0, eis_pkg::OFS_STAMP, 32'h0);
        a = rd;
        bus(1'b0, eis_pkg::OFS_STAMP, 32'h0);
        check(rd - a, 32'h3);
        bus(1'b1, eis_pkg::OFS_NMI_CONTROL, 32'h0000_0009);
        bus(1'b0, eis_pkg::OFS_STAMP, 32'h0);
        a = rd;
        bus(1'b0, eis_pkg::OFS_STAMP, 32'h0);
        check(rd, a);
        pulse(sel);
        check(32'(d[2]), 32'h2);
        check(32'(d[3]), 32'h0);
        // Select without enable is neither redirect nor a live nonmaskable input.
        bus(1'b1, eis_pkg::OFS_NMI_CONTROL, 32'h0000_000A);
        pulse(sel);
        check(32'(d[2]), 32'h0);
        check(32'(d[3]), 32'h0);
        a = $urandom;
        bus(1'b1, eis_pkg::OFS_STAMP, a);
        bus(1'b0, eis_pkg::OFS_STAMP, 32'h0);
        check(rd, a);
        gpio_pins <= $urandom;
        repeat (4) @(posedge hclk);
        bus(1'b0, eis_pkg::OFS_PIN_STATUS, 32'h0);
        a = {29'h0, gpio_pins[sel_of[2]], gpio_pins[sel_of[1]], gpio_pins[sel_of[0]]};
        check(rd, a);
        $display("test redirect done");
        close_out();
    end
endmodule
